// ===== sgc_params.svh
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH


// register indices; byte address is four times the index
`define SGC_IDX_CLK_SEL 8'h0B
`define SGC_IDX_MAP_LO 8'h0C
`define SGC_IDX_MAP_HI 8'h0D
`define SGC_IDX_UNK_FWD 8'h0E
`define SGC_IDX_STATUS 8'h40

// field positions
`define SGC_CLK_SEL_MSB 7
`define SGC_CLK_SEL_LSB 6
`define SGC_UNK_EN_BIT 7
`define SGC_DRIVE_BIT 6
`define SGC_UNK_MASK_MSB 2

// reset and fixed values
`define SGC_CLK_SEL_RST 2'b10
`define SGC_CLK_RSVD_VAL 6'h08
`define SGC_MAP_LO_RST 8'h50
`define SGC_MAP_HI_RST 8'hFA
`define SGC_UNK_EN_RST 1'b0
`define SGC_DRIVE_RST 1'b1
`define SGC_UNK_MASK_RST 3'b111
`define SGC_UNK_RSVD_VAL 3'b000

// bus answers
`define SGC_RESP_OKAY 2'b00
`define SGC_RESP_SLVERR 2'b10

`endif

// ===== sgc_pkg.sv
`default_nettype none

package sgc_pkg;

   // host-interface internal clock codes
   typedef enum logic [1:0] {
      SGC_CLK_31M25 = 2'b00,
      SGC_CLK_62M5 = 2'b01,
      SGC_CLK_125M = 2'b10
   } sgc_clk_sel_t;

   // decoded register selection
   typedef enum logic [2:0] {
      SGC_SEL_NONE = 3'b000,
      SGC_SEL_CLK = 3'b001,
      SGC_SEL_MAP_LO = 3'b010,
      SGC_SEL_MAP_HI = 3'b011,
      SGC_SEL_UNK = 3'b100,
      SGC_SEL_STATUS = 3'b101
   } sgc_reg_sel_t;

   typedef struct packed {
      logic valid;
      logic [1:0] queue;
   } sgc_lookup_state_t;

   typedef struct packed {
      logic valid;
      logic apply;
      logic [2:0] ports;
   } sgc_fwd_state_t;

   typedef struct packed {
      logic aw_held;
      sgc_reg_sel_t aw_sel;
      logic w_held;
      logic [7:0] w_byte;
      logic w_lane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      sgc_clk_sel_t clk_sel;
      logic [7:0] map_lo;
      logic [7:0] map_hi;
      logic unk_en;
      logic drive_strong;
      logic [2:0] unk_mask;
      logic [7:0] tag_cnt;
      logic [7:0] unk_cnt;
   } sgc_regs_state_t;

endpackage

`default_nettype wire

// ===== sgc_prio_lookup.sv
`timescale 1ns/1ps
`default_nettype none

module sgc_prio_lookup
   import sgc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // mapping tables
   input wire logic [7:0] map_lo,
   input wire logic [7:0] map_hi,
   // tagged frame request
   input wire logic tag_valid,
   input wire logic [2:0] tag_value,
   // queue answer
   output logic prio_valid,
   output logic [1:0] prio_queue
);

   logic [1:0] table_w [8];
   sgc_lookup_state_t st_q;
   sgc_lookup_state_t st_d;

   // unpack both registers into eight two-bit entries
   for (genvar i = 0; i < 4; i++) begin : g_entry
      assign table_w[i] = map_lo[2*i+1:2*i];
      assign table_w[i+4] = map_hi[2*i+1:2*i];
   end

   // one-cycle registered lookup
   always_comb begin
      st_d = st_q;
      st_d.valid = tag_valid;
      if (tag_valid) begin
         st_d.queue = table_w[tag_value];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign prio_valid = st_q.valid;
   assign prio_queue = st_q.queue;

endmodule

`default_nettype wire

// ===== sgc_unknown_fwd.sv
`timescale 1ns/1ps
`default_nettype none

module sgc_unknown_fwd
   import sgc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // configuration
   input wire logic fwd_en,
   input wire logic [2:0] fwd_mask,
   // lookup miss request
   input wire logic miss_valid,
   // forwarding answer
   output logic fwd_valid,
   output logic fwd_apply,
   output logic [2:0] fwd_ports
);

   sgc_fwd_state_t st_q;
   sgc_fwd_state_t st_d;

   // disabled: no default ports, switch keeps its normal unknown handling
   always_comb begin
      st_d = st_q;
      st_d.valid = miss_valid;
      if (miss_valid) begin
         st_d.apply = fwd_en;
         st_d.ports = fwd_en ? fwd_mask : 3'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign fwd_valid = st_q.valid;
   assign fwd_apply = st_q.apply;
   assign fwd_ports = st_q.ports;

endmodule

`default_nettype wire

// ===== sgc_global_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

`include "sgc_params.svh"

module sgc_global_config_regs
   import sgc_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data channel
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response channel
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address channel
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data channel
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration towards the switch core and pads
   output logic [1:0] host_clk_sel,
   output logic pad_drive_16ma,
   output logic unknown_fwd_en,
   output logic [2:0] unknown_fwd_ports,
   // tagged frame priority lookup
   input wire logic tag_valid,
   input wire logic [2:0] tag_value,
   output logic prio_valid,
   output logic [1:0] prio_queue,
   // unknown destination lookup
   input wire logic miss_valid,
   output logic fwd_valid,
   output logic fwd_apply,
   output logic [2:0] fwd_ports
);

   sgc_regs_state_t st_q;
   sgc_regs_state_t st_d;

   logic aw_take;
   logic w_take;
   logic ar_take;
   logic wr_fire;
   sgc_reg_sel_t wr_sel;
   logic [7:0] wr_byte;
   logic wr_lane;
   sgc_reg_sel_t rd_sel;

   // byte address to register selection; misaligned or unmapped gives none
   function automatic sgc_reg_sel_t decode_addr(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W-1:0] idx;
      idx = addr >> 2;
      decode_addr = SGC_SEL_NONE;
      if (addr[1:0] == 2'b00) begin
         if (idx == ADDR_W'(`SGC_IDX_CLK_SEL)) begin
            decode_addr = SGC_SEL_CLK;
         end else if (idx == ADDR_W'(`SGC_IDX_MAP_LO)) begin
            decode_addr = SGC_SEL_MAP_LO;
         end else if (idx == ADDR_W'(`SGC_IDX_MAP_HI)) begin
            decode_addr = SGC_SEL_MAP_HI;
         end else if (idx == ADDR_W'(`SGC_IDX_UNK_FWD)) begin
            decode_addr = SGC_SEL_UNK;
         end else if (idx == ADDR_W'(`SGC_IDX_STATUS)) begin
            decode_addr = SGC_SEL_STATUS;
         end
      end
   endfunction

   // reserved bits are rebuilt from constants, never from storage
   function automatic logic [31:0] read_word(input sgc_reg_sel_t sel, input sgc_regs_state_t s);
      read_word = 32'h0000_0000;
      unique case (sel)
         SGC_SEL_CLK: begin
            read_word[7:0] = {s.clk_sel, `SGC_CLK_RSVD_VAL};
         end
         SGC_SEL_MAP_LO: begin
            read_word[7:0] = s.map_lo;
         end
         SGC_SEL_MAP_HI: begin
            read_word[7:0] = s.map_hi;
         end
         SGC_SEL_UNK: begin
            read_word[7:0] = {s.unk_en, s.drive_strong, `SGC_UNK_RSVD_VAL, s.unk_mask};
         end
         SGC_SEL_STATUS: begin
            read_word[15:0] = {s.unk_cnt, s.tag_cnt};
         end
         SGC_SEL_NONE: begin
            read_word = 32'h0000_0000;
         end
      endcase
   endfunction

   // handshake readies; a pending response blocks new writes
   assign s_axi_awready = !st_q.aw_held && !st_q.bvalid;
   assign s_axi_wready = !st_q.w_held && !st_q.bvalid;
   assign s_axi_arready = !st_q.rvalid;

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;

   // a write fires once address and data are both in hand, in either order
   assign wr_fire = (st_q.aw_held || aw_take) && (st_q.w_held || w_take);
   assign wr_sel = st_q.aw_held ? st_q.aw_sel : decode_addr(s_axi_awaddr);
   assign wr_byte = st_q.w_held ? st_q.w_byte : s_axi_wdata[7:0];
   assign wr_lane = st_q.w_held ? st_q.w_lane : s_axi_wstrb[0];
   assign rd_sel = decode_addr(s_axi_araddr);

   // next state of the whole register bank and bus slave
   always_comb begin
      st_d = st_q;

      // capture address or data arriving ahead of its partner
      if (aw_take && !wr_fire) begin
         st_d.aw_held = 1'b1;
         st_d.aw_sel = decode_addr(s_axi_awaddr);
      end
      if (w_take && !wr_fire) begin
         st_d.w_held = 1'b1;
         st_d.w_byte = s_axi_wdata[7:0];
         st_d.w_lane = s_axi_wstrb[0];
      end

      // response retires when the master takes it
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end

      // event counters; both counters saturate at FF instead of wrapping, so software sees activity
      if (tag_valid && st_q.tag_cnt != 8'hFF) begin
         st_d.tag_cnt = st_q.tag_cnt + 8'h01;
      end
      if (miss_valid && st_q.unk_cnt != 8'hFF) begin
         st_d.unk_cnt = st_q.unk_cnt + 8'h01;
      end

      // commit a write; only byte lane 0 carries register data
      if (wr_fire) begin
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = (wr_sel == SGC_SEL_NONE) ? `SGC_RESP_SLVERR : `SGC_RESP_OKAY;
         if (wr_lane) begin
            unique case (wr_sel)
               SGC_SEL_CLK: begin
                  // code 11 names no clock, so the field keeps its value
                  if (wr_byte[`SGC_CLK_SEL_MSB:`SGC_CLK_SEL_LSB] != 2'b11) begin
                     st_d.clk_sel = sgc_clk_sel_t'(wr_byte[`SGC_CLK_SEL_MSB:`SGC_CLK_SEL_LSB]);
                  end
               end
               SGC_SEL_MAP_LO: begin
                  st_d.map_lo = wr_byte;
               end
               SGC_SEL_MAP_HI: begin
                  st_d.map_hi = wr_byte;
               end
               SGC_SEL_UNK: begin
                  st_d.unk_en = wr_byte[`SGC_UNK_EN_BIT];
                  st_d.drive_strong = wr_byte[`SGC_DRIVE_BIT];
                  st_d.unk_mask = wr_byte[`SGC_UNK_MASK_MSB:0]; // bits 5-3 dropped
               end
               SGC_SEL_STATUS: begin
                  // a write with byte lane 0 strobed clears both counters; a same-cycle event still counts
                  st_d.tag_cnt = {7'h00, tag_valid};
                  st_d.unk_cnt = {7'h00, miss_valid};
               end
               SGC_SEL_NONE: begin
                  st_d.bresp = `SGC_RESP_SLVERR;
               end
            endcase
         end
      end

      // read: data are sampled at the address handshake
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (ar_take) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = read_word(rd_sel, st_q);
         st_d.rresp = (rd_sel == SGC_SEL_NONE) ? `SGC_RESP_SLVERR : `SGC_RESP_OKAY;
      end
   end

   // reset loads the power-up defaults
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.aw_sel <= SGC_SEL_NONE;
         st_q.clk_sel <= sgc_clk_sel_t'(`SGC_CLK_SEL_RST);
         st_q.map_lo <= `SGC_MAP_LO_RST;
         st_q.map_hi <= `SGC_MAP_HI_RST;
         st_q.unk_en <= `SGC_UNK_EN_RST;
         st_q.drive_strong <= `SGC_DRIVE_RST;
         st_q.unk_mask <= `SGC_UNK_MASK_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // bus outputs straight from state
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;

   // configuration outputs
   assign host_clk_sel = st_q.clk_sel;
   assign pad_drive_16ma = st_q.drive_strong;
   assign unknown_fwd_en = st_q.unk_en;
   assign unknown_fwd_ports = st_q.unk_mask;

   // priority lookup for tagged frames
   sgc_prio_lookup u_prio (
      .aclk(aclk),
      .aresetn(aresetn),
      .map_lo(st_q.map_lo),
      .map_hi(st_q.map_hi),
      .tag_valid(tag_valid),
      .tag_value(tag_value),
      .prio_valid(prio_valid),
      .prio_queue(prio_queue)
   );

   // default ports for unknown destinations
   sgc_unknown_fwd u_fwd (
      .aclk(aclk),
      .aresetn(aresetn),
      .fwd_en(st_q.unk_en),
      .fwd_mask(st_q.unk_mask),
      .miss_valid(miss_valid),
      .fwd_valid(fwd_valid),
      .fwd_apply(fwd_apply),
      .fwd_ports(fwd_ports)
   );

endmodule

`default_nettype wire

// ===== sgc_global_config_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

module sgc_global_config_regs_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awready,
   input wire logic s_axi_arready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // configuration
   input wire logic [1:0] host_clk_sel,
   input wire logic pad_drive_16ma,
   input wire logic unknown_fwd_en,
   input wire logic [2:0] unknown_fwd_ports,
   // lookups
   input wire logic tag_valid,
   input wire logic prio_valid,
   input wire logic miss_valid,
   input wire logic fwd_valid,
   input wire logic fwd_apply,
   input wire logic [2:0] fwd_ports
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // one answer per request, exactly one cycle later
   a_prio_pulse: assert property (tag_valid |=> prio_valid)
      else $error("priority answer missing");
   a_prio_idle: assert property (!tag_valid |=> !prio_valid)
      else $error("priority answer without request");
   // forward decision uses the settings of the request cycle
   a_fwd_value: assert property (miss_valid |=> fwd_valid && fwd_apply == $past(unknown_fwd_en)
      && fwd_ports == ($past(unknown_fwd_en) ? $past(unknown_fwd_ports) : 3'b000))
      else $error("forward answer wrong");
   a_clk_legal: assert property (host_clk_sel != 2'b11)
      else $error("illegal clock code");
   // settings move only with a write answer, never by themselves
   a_cfg_write: assert property ($changed({host_clk_sel, pad_drive_16ma, unknown_fwd_en,
      unknown_fwd_ports}) |-> $rose(s_axi_bvalid))
      else $error("setting changed without write");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped");
   a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while answer pending");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule

bind sgc_global_config_regs sgc_global_config_regs_props u_props (.aclk, .aresetn, .s_axi_awready,
   .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .host_clk_sel,
   .pad_drive_16ma, .unknown_fwd_en, .unknown_fwd_ports, .tag_valid, .prio_valid, .miss_valid,
   .fwd_valid, .fwd_apply, .fwd_ports);

`default_nettype wire

// ===== sgc_global_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

`include "sgc_params.svh"

module sgc_global_config_regs_tb;
   localparam logic [11:0] A_CLK = {2'b00, `SGC_IDX_CLK_SEL, 2'b00};
   localparam logic [11:0] A_LO = {2'b00, `SGC_IDX_MAP_LO, 2'b00};
   localparam logic [11:0] A_HI = {2'b00, `SGC_IDX_MAP_HI, 2'b00};
   localparam logic [11:0] A_UNK = {2'b00, `SGC_IDX_UNK_FWD, 2'b00};
   localparam logic [11:0] A_STAT = {2'b00, `SGC_IDX_STATUS, 2'b00};
   localparam logic [1:0] OK = `SGC_RESP_OKAY;
   localparam logic [1:0] ERR = `SGC_RESP_SLVERR;

   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, pad_drive_16ma, unknown_fwd_en;
   logic tag_valid, prio_valid, miss_valid, fwd_valid, fwd_apply;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [2:0] prot, unknown_fwd_ports, tag_value, fwd_ports;
   logic [1:0] s_axi_bresp, s_axi_rresp, host_clk_sel, prio_queue;
   logic [15:0] map;
   int fails, n_tests;

   sgc_global_config_regs #(.ADDR_W(12)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(prot),
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(prot), .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_clk_sel,
      .pad_drive_16ma, .unknown_fwd_en, .unknown_fwd_ports, .tag_valid, .tag_value, .prio_valid,
      .prio_queue, .miss_valid, .fwd_valid, .fwd_apply, .fwd_ports);

   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task tmo(input int i);
      if (i >= 50) begin
         fails++;
         final_report;
      end
   endtask

   // ready is raised late on purpose so the answer has to stand
   task wr(input logic [11:0] a, input logic [7:0] d, input logic s, input logic [1:0] er);
      int i;
      s_axi_awaddr <= a;
      s_axi_wdata <= 32'(d);
      s_axi_wstrb <= {3'b000, s};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) break;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      tmo(i);
      chk(32'(s_axi_bresp), 32'(er));
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int i;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) break;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      tmo(i);
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // pins: clock code, drive, enable, mask
   task cfg(input logic [6:0] e);
      chk(32'({host_clk_sel, pad_drive_16ma, unknown_fwd_en, unknown_fwd_ports}), 32'(e));
   endtask

   // all eight tags and misses back to back, answers checked a cycle behind
   task burst(input logic en, input logic [2:0] m);
      int i;
      for (i = 0; i <= 8; i++) begin
         tag_valid <= (i < 8);
         miss_valid <= (i < 8);
         tag_value <= 3'(i);
         @(posedge aclk);
         if (i > 0) begin
            chk(32'({prio_valid, prio_queue}), 32'({1'b1, map[2*(i-1)+:2]}));
            chk(32'({fwd_valid, fwd_apply, fwd_ports}), 32'({1'b1, en, en ? m : 3'b000}));
         end
      end
   endtask

   // free-running core clock
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end

   // main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, prot} = '0;
      {tag_valid, miss_valid, tag_value} = '0;
      fails = 0;
      n_tests = 0;
      map = 16'hFA50;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_CLK, 32'h0000_0088, OK);
      rd(A_LO, 32'h0000_0050, OK);
      rd(A_HI, 32'h0000_00FA, OK);
      rd(A_UNK, 32'h0000_0047, OK);
      cfg(7'h57);
      burst(1'b0, 3'b111);
      // tags 0-3 take queues 3-0 and tags 4-7 take queues 0-3, reserved bits written high
      wr(A_LO, 8'h1B, 1'b1, OK);
      wr(A_HI, 8'hE4, 1'b1, OK);
      map = 16'hE41B;
      wr(A_UNK, 8'hFD, 1'b1, OK);
      rd(A_UNK, 32'h0000_00C5, OK);
      burst(1'b1, 3'b101);
      // lookup counters, then cleared by a write
      rd(A_STAT, 32'h0000_1010, OK);
      wr(A_STAT, 8'h00, 1'b1, OK);
      rd(A_STAT, 32'h0000_0000, OK);
      // a long run of lookups must stop both counters at their top
      tag_valid <= 1'b1;
      miss_valid <= 1'b1;
      repeat (260) @(posedge aclk);
      tag_valid <= 1'b0;
      miss_valid <= 1'b0;
      rd(A_STAT, 32'h0000_FFFF, OK);
      // clock codes 01, 00, then illegal 11 ignored
      wr(A_CLK, 8'h7F, 1'b1, OK);
      rd(A_CLK, 32'h0000_0048, OK);
      wr(A_CLK, 8'h00, 1'b1, OK);
      wr(A_CLK, 8'hC0, 1'b1, OK);
      rd(A_CLK, 32'h0000_0008, OK);
      // weak drive, forwarding off; strobe low changes nothing
      wr(A_UNK, 8'h02, 1'b1, OK);
      wr(A_UNK, 8'hFF, 1'b0, OK);
      cfg(7'h02);
      wr(A_CLK, 8'h80, 1'b1, OK);
      cfg(7'h42);
      // unmapped and misaligned places refuse and keep quiet
      wr(12'h03C, 8'hFF, 1'b1, ERR);
      wr(A_LO + 12'h001, 8'hFF, 1'b1, ERR);
      rd(12'h03C, 32'h0000_0000, ERR);
      rd(A_LO, 32'h0000_001B, OK);
      // mid-run reset must bring clock code, drive, forwarding and map_lo back to their defaults; map_hi is not read back
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      cfg(7'h57);
      rd(A_LO, 32'h0000_0050, OK);
      rd(A_UNK, 32'h0000_0047, OK);
      final_report;
   end
endmodule

`default_nettype wire
